//--- verilog/ccp_pkg.sv
// Behaviour
// - Pixel clock, syncs and data lines are inputs only; never driven.
// - Data width selectable as 8, 10, 12 or 14 lines.
// - Embedded sync uses eight data lines and pixel clock; syncs unused.
// - One sample per pixel clock, packed into a 32-bit word.
// - Words pass a four-entry FIFO that refuses writes when full.
// - Overrun or sync error flushes FIFO; capture resumes at next frame, or at once in embedded sync mode.
// - A sequencer orders flow through extractor, FIFO and word register.
// - 8-bit mode takes the lowest eight lines, ignores upper six.
// - 8-bit mode: first byte in bits 7..0, fourth in bits 31..24.
// - 8-bit mode completes a word every four valid pixel clocks.
// - 10-bit mode: ten lines, right-aligned in 16-bit half, rest zero.
// - 12-bit mode: twelve lines, right-aligned in 16-bit half, rest zero.
// - 14-bit mode: all fourteen lines, bits 14 and 15 of half zero.
// - Wide modes: word every two clocks, first sample in lower half.
// - A complete word in the output register raises a DMA request.
// - Hardware sync: samples during active line or frame sync dropped.
// - Sampling edge and sync polarities are configurable.
package ccp_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_LINES = 14;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================
  // Width select encodings
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_10 = 2'h1;
  localparam logic [1:0] WIDTH_12 = 2'h2;
  localparam logic [1:0] WIDTH_14 = 2'h3;

  // Last lane index before a word is complete
  localparam logic [1:0] LAST_LANE_8 = 2'h3;
  localparam logic [1:0] LAST_LANE_WIDE = 2'h1;

  // Reset value of the output word
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    CCP_WAIT_BLANK = 2'b00,
    CCP_WAIT_START = 2'b01,
    CCP_CAPTURE = 2'b10
  } ccp_state_t;

endpackage

//--- verilog/ccp_fifo.sv
`timescale 1ns/1ps
module ccp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic do_wr, do_rd;

  // ==========================================================
  // Pointer and count update
  always_comb begin
    do_wr = wr_valid && wr_ready;
    do_rd = rd_valid && rd_ready;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (flush) begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_cnt = '0;
    end else begin
      if (do_wr) nxt_wp = (wp_ff == LAST) ? '0 : wp_ff + 1'b1;
      if (do_rd) nxt_rp = (rp_ff == LAST) ? '0 : rp_ff + 1'b1;
      if (do_wr && !do_rd) nxt_cnt = cnt_ff + 1'b1;
      else if (do_rd && !do_wr) nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk) begin
    if (do_wr && !flush) mem_ff[wp_ff] <= wr_data;
  end

  // Full FIFO refuses writes; the writer sees it as an overrun
  assign wr_ready = (cnt_ff != DEPTH_C);
  assign rd_valid = (cnt_ff != '0);
  assign rd_data = mem_ff[rp_ff];
endmodule

//--- verilog/ccp_capture.sv
`timescale 1ns/1ps
module ccp_capture
  import ccp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pixel_clock_in,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic [ccp_pkg::DATA_LINES-1:0] pixel_data_lines,
  input wire logic capture_enable,
  input wire logic [1:0] width_sel,
  input wire logic embedded_sync_en,
  input wire logic pclk_rising_edge,
  input wire logic line_sync_active_high,
  input wire logic frame_sync_active_high,
  input wire logic word_read,
  output logic [ccp_pkg::WORD_W-1:0] captured_pixel_word,
  output logic dma_request,
  output logic overrun_pulse,
  output logic sync_error_pulse,
  output logic capture_active
);
  import ccp_pkg::*;

  // ==========================================================
  // Input synchronisers: every camera pin is input only
  logic [1:0] pclk_sy_ff, hs_sy_ff, vs_sy_ff;
  logic [DATA_LINES-1:0] d1_ff, d2_ff;
  logic pclk_prev_ff, vact_prev_ff;

  // Two stages before any logic reads a pin; data rides in step
  always_ff @(posedge clk) begin
    if (rst) begin
      pclk_sy_ff <= '0;
      hs_sy_ff <= '0;
      vs_sy_ff <= '0;
      d1_ff <= '0;
      d2_ff <= '0;
    end else begin
      pclk_sy_ff <= {pclk_sy_ff[0], pixel_clock_in};
      hs_sy_ff <= {hs_sy_ff[0], line_sync_in};
      vs_sy_ff <= {vs_sy_ff[0], frame_sync_in};
      d1_ff <= pixel_data_lines;
      d2_ff <= d1_ff;
    end
  end

  // ==========================================================
  // Extractor helpers
  function automatic logic [15:0] wide_sample(
    input logic [DATA_LINES-1:0] d,
    input logic [1:0] w
  );
    logic [15:0] r;
    r = {2'h0, d};
    unique case (w)
      WIDTH_10: r = {6'h00, d[9:0]};
      WIDTH_12: r = {4'h0, d[11:0]};
      default: r = {2'h0, d[13:0]};
    endcase
    return r;
  endfunction

  // ==========================================================
  // Edge and blanking detection
  logic pclk_edge, hact, vact, line_valid, frame_start, sample_ok;
  logic [1:0] eff_width;

  always_comb begin
    // Sampling edge follows configuration
    pclk_edge = pclk_rising_edge ? (pclk_sy_ff[1] && !pclk_prev_ff)
                                 : (!pclk_sy_ff[1] && pclk_prev_ff);
    hact = (hs_sy_ff[1] == line_sync_active_high);
    vact = (vs_sy_ff[1] == frame_sync_active_high);
    frame_start = vact_prev_ff && !vact;
    // Embedded mode ignores both syncs and the upper lines
    eff_width = embedded_sync_en ? WIDTH_8 : width_sel;
    line_valid = embedded_sync_en || (!hact && !vact);
    sample_ok = pclk_edge && line_valid;
  end

  // ==========================================================
  // Sequencer, packer and output word register
  ccp_state_t state_ff, nxt_state;
  logic [1:0] pos_ff, nxt_pos;
  logic [WORD_W-1:0] pack_ff, nxt_pack;
  logic [WORD_W-1:0] word_ff, nxt_word;
  logic dreq_ff, nxt_dreq, ovr_ff, nxt_ovr, err_ff, nxt_err;
  logic push, flush, wr_ready, rd_valid, rd_ready;
  logic [WORD_W-1:0] rd_data, push_word;
  logic [1:0] last_lane;
  logic act_ff, nxt_act;

  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    nxt_pack = pack_ff;
    nxt_ovr = 1'b0;
    nxt_err = 1'b0;
    push = 1'b0;
    flush = 1'b0;
    push_word = pack_ff;
    last_lane = (eff_width == WIDTH_8) ? LAST_LANE_8 : LAST_LANE_WIDE;
    if (!capture_enable) begin
      nxt_state = CCP_WAIT_BLANK;
      nxt_pos = '0;
      flush = 1'b1;
    end else begin
      unique case (state_ff)
        CCP_WAIT_BLANK: begin
          if (embedded_sync_en) nxt_state = CCP_CAPTURE;
          else if (vact) nxt_state = CCP_WAIT_START;
        end
        CCP_WAIT_START: begin
          if (embedded_sync_en || !vact) begin
            nxt_state = CCP_CAPTURE;
            nxt_pos = '0;
          end
        end
        CCP_CAPTURE: begin
          if (!embedded_sync_en && frame_start && !hact) begin
            // Frame opened mid-line: sync error
            nxt_err = 1'b1;
          end else if (!embedded_sync_en && vact) begin
            nxt_pos = '0;
          end else if (sample_ok) begin
            if (eff_width == WIDTH_8) begin
              push_word[pos_ff*8 +: 8] = d2_ff[7:0];
            end else if (pos_ff[0]) begin
              push_word[31:16] = wide_sample(d2_ff, eff_width);
            end else begin
              push_word[15:0] = wide_sample(d2_ff, eff_width);
            end
            nxt_pack = push_word;
            if (pos_ff == last_lane) begin
              nxt_pos = '0;
              push = 1'b1;
              nxt_ovr = !wr_ready;
            end else begin
              nxt_pos = pos_ff + 2'h1;
            end
          end
        end
        default: nxt_state = CCP_WAIT_BLANK;
      endcase
      if (nxt_ovr || nxt_err) begin
        // Drop everything; wait for a fresh frame, or restart at once in embedded mode
        flush = 1'b1;
        nxt_pos = '0;
        nxt_state = CCP_WAIT_BLANK;
      end
    end
    // Registered copy keeps the status pin glitch free
    nxt_act = (nxt_state == CCP_CAPTURE);
  end

  // Output word loads whenever it is empty or being read
  always_comb begin
    rd_ready = !dreq_ff || word_read;
    nxt_word = word_ff;
    nxt_dreq = dreq_ff;
    if (flush) begin
      nxt_dreq = 1'b0;
      nxt_word = WORD_RESET;
    end else if (rd_valid && rd_ready) begin
      nxt_word = rd_data;
      nxt_dreq = 1'b1;
    end else if (word_read) begin
      nxt_dreq = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= CCP_WAIT_BLANK;
      pos_ff <= '0;
      pack_ff <= WORD_RESET;
      word_ff <= WORD_RESET;
      dreq_ff <= 1'b0;
      ovr_ff <= 1'b0;
      err_ff <= 1'b0;
      act_ff <= 1'b0;
      pclk_prev_ff <= 1'b0;
      vact_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
      pack_ff <= nxt_pack;
      word_ff <= nxt_word;
      dreq_ff <= nxt_dreq;
      ovr_ff <= nxt_ovr;
      err_ff <= nxt_err;
      act_ff <= nxt_act;
      pclk_prev_ff <= pclk_sy_ff[1];
      vact_prev_ff <= vact;
    end
  end

  // ==========================================================
  // Four-word FIFO; a push into a full FIFO is lost and flagged
  ccp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .wr_valid(push),
    .wr_ready(wr_ready),
    .wr_data(push_word),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_data)
  );

  // Outputs straight from flip-flops
  assign captured_pixel_word = word_ff;
  assign dma_request = dreq_ff;
  assign overrun_pulse = ovr_ff;
  assign sync_error_pulse = err_ff;
  assign capture_active = act_ff;
endmodule

//--- sim/ccp_capture_properties.sv
`timescale 1ns/1ps
module ccp_capture_properties
  import ccp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic capture_enable,
  input wire logic [1:0] width_sel,
  input wire logic embedded_sync_en,
  input wire logic word_read,
  input wire logic [ccp_pkg::WORD_W-1:0] captured_pixel_word,
  input wire logic dma_request,
  input wire logic overrun_pulse,
  input wire logic sync_error_pulse,
  input wire logic capture_active
);
  // ==========================================================
  // Word and request checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] w;
  logic wide;
  // Padding checks only hold once a word is really on offer
  assign w = captured_pixel_word;
  assign wide = dma_request && capture_enable && !embedded_sync_en;
  chk_idle_flush: assert property (
    !capture_enable [*3] |-> !dma_request && !capture_active && w == 32'h0)
    else $error("word kept while disabled");
  chk_ovr_flush: assert property (
    overrun_pulse |=> !dma_request && w == 32'h0)
    else $error("word kept after overrun");
  chk_ovr_single: assert property (
    overrun_pulse |=> !overrun_pulse)
    else $error("overrun pulse too long");
  chk_serr_flush: assert property (
    sync_error_pulse |=> !dma_request && !capture_active && !sync_error_pulse)
    else $error("capture kept after sync error");
  chk_req_holds: assert property (
    dma_request && capture_enable && !word_read |=>
    dma_request || overrun_pulse || sync_error_pulse)
    else $error("request dropped without read");
  chk_word_holds: assert property (
    dma_request && !word_read |=> $stable(w) || !dma_request)
    else $error("word changed while unread");
  chk_pad_ten: assert property (
    wide && width_sel == WIDTH_10 |-> (w & 32'hFC00_FC00) == 32'h0)
    else $error("pad bits set in 10-bit word");
  chk_pad_twelve: assert property (
    wide && width_sel == WIDTH_12 |-> (w & 32'hF000_F000) == 32'h0)
    else $error("pad bits set in 12-bit word");
  chk_pad_fourteen: assert property (
    wide && width_sel == WIDTH_14 |-> (w & 32'hC000_C000) == 32'h0)
    else $error("pad bits set in 14-bit word");
endmodule

bind ccp_capture ccp_capture_properties chk_u (.clk(clk), .rst(rst),
  .capture_enable(capture_enable), .width_sel(width_sel),
  .embedded_sync_en(embedded_sync_en), .word_read(word_read),
  .captured_pixel_word(captured_pixel_word), .dma_request(dma_request),
  .overrun_pulse(overrun_pulse), .sync_error_pulse(sync_error_pulse),
  .capture_active(capture_active));

//--- sim/ccp_camera_model.sv
`timescale 1ns/1ps
module ccp_camera_model (
  output logic pclk,
  output logic lsync,
  output logic fsync,
  output logic [13:0] data
);
  // ==========================================================
  // Idle link: clock still, both syncs blanking
  logic rise = 1'b1, lpol = 1'b1, fpol = 1'b1;
  initial begin
    pclk = 1'b0;
    lsync = 1'b1;
    fsync = 1'b1;
    data = 14'h0000;
  end
  // Sensor setup; only takes effect on the next pixel or frame
  task automatic cfg(input logic r, input logic lp, input logic fp);
    rise = r;
    lpol = lp;
    fpol = fp;
  endtask
  // One pixel; data moves on the edge the port does not sample
  task automatic pix(input logic [13:0] d, input logic lb);
    // Park the clock first, else a new edge setting eats a pixel
    pclk = !rise;
    lsync = lb ~^ lpol;
    data = d;
    #100 pclk = rise;
    #100 pclk = !rise;
  endtask
  // Frame blanking; err leaves the line valid as the frame starts
  task automatic frame(input logic err);
    pclk = !rise;
    fsync = fpol;
    lsync = lpol;
    data = ~data;
    #500 lsync = err ? !lpol : lpol;
    #300 fsync = !fpol;
    #500 lsync = lpol;
  endtask
endmodule

//--- sim/ccp_capture_bench.sv
`timescale 1ns/1ps
module ccp_capture_bench;
  import ccp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, emb = 1'b0, rd = 1'b0;
  logic rise = 1'b1, lpol = 1'b1, fpol = 1'b1;
  logic [1:0] wsel = WIDTH_8;
  logic pclk, lsync, fsync, req, ovr, serr, act;
  logic ovr_seen = 1'b0, serr_seen = 1'b0;
  logic [13:0] data;
  logic [31:0] word;
  int errors = 0, n_tests = 0;

  // ==========================================================
  // Clock, camera, port under test
  always #12.5 clk = ~clk;
  ccp_camera_model cam_u (.pclk(pclk), .lsync(lsync), .fsync(fsync),
    .data(data));
  ccp_capture dut_u (.clk(clk), .rst(rst), .pixel_clock_in(pclk),
    .line_sync_in(lsync), .frame_sync_in(fsync), .pixel_data_lines(data),
    .capture_enable(en), .width_sel(wsel), .embedded_sync_en(emb),
    .pclk_rising_edge(rise), .line_sync_active_high(lpol),
    .frame_sync_active_high(fpol), .word_read(rd),
    .captured_pixel_word(word), .dma_request(req), .overrun_pulse(ovr),
    .sync_error_pulse(serr), .capture_active(act));
  // Pulses last one cycle, so remember them for later checks
  always @(posedge clk) begin
    if (ovr === 1'b1) ovr_seen <= 1'b1;
    if (serr === 1'b1) serr_seen <= 1'b1;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Config only moves while capture is off
  task automatic setup(input logic [1:0] w, input logic e, r, lp, fp);
    @(posedge clk) en <= 1'b0;
    wsel <= w;
    emb <= e;
    rise <= r;
    lpol <= lp;
    fpol <= fp;
    cam_u.cfg(r, lp, fp);
    ovr_seen <= 1'b0;
    serr_seen <= 1'b0;
    repeat (4) @(posedge clk);
    en <= 1'b1;
  endtask
  // Bytes b0, b0+1, ... with upper lines high; blk adds blank pixels
  task automatic bytes(input logic [7:0] b0, input int n, input logic blk);
    for (int i = 0; i < n; i++) begin
      cam_u.pix({6'h3F, b0 + 8'(i)}, 1'b0);
      if (blk) cam_u.pix(14'h3FFF, 1'b1);
    end
  endtask
  function automatic logic [31:0] w4(input logic [7:0] b);
    return {b + 8'h03, b + 8'h02, b + 8'h01, b};
  endfunction
  task automatic get(input logic [31:0] exp);
    int k;
    k = 0;
    @(negedge clk);
    while (req !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    check(req, 32'h1);
    check(word, exp);
    @(posedge clk) rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_pack8;
    setup(WIDTH_8, 1'b0, 1'b1, 1'b1, 1'b1);
    cam_u.frame(1'b0);
    bytes(8'h11, 8, 1'b1);
    get(w4(8'h11));
    get(w4(8'h15));
    bytes(8'h60, 2, 1'b0);
    cam_u.frame(1'b0);
    bytes(8'h21, 4, 1'b0);
    get(w4(8'h21));
  endtask
  task automatic t_wide;
    logic [15:0] m;
    for (int w = 1; w < 4; w++) begin
      m = 16'((32'h1 << (8 + 2 * w)) - 1);
      // Frame polarity alternates across the wide modes
      setup(2'(w), 1'b0, 1'b1, 1'b1, w[0]);
      cam_u.frame(1'b0);
      cam_u.pix(14'h3FFF, 1'b0);
      cam_u.pix(14'h2AAA, 1'b0);
      get({m & 16'h2AAA, m & 16'h3FFF});
    end
  endtask
  task automatic t_overrun;
    setup(WIDTH_8, 1'b0, 1'b1, 1'b1, 1'b1);
    cam_u.frame(1'b0);
    bytes(8'h01, 24, 1'b0);
    repeat (6) @(negedge clk);
    check({ovr_seen, req}, 2'b10);
    cam_u.frame(1'b0);
    bytes(8'h41, 4, 1'b0);
    get(w4(8'h41));
  endtask
  task automatic t_syncerr;
    setup(WIDTH_8, 1'b0, 1'b1, 1'b1, 1'b1);
    // The error is judged only once capture is running
    cam_u.frame(1'b0);
    @(negedge clk);
    check(act, 32'h1);
    cam_u.frame(1'b1);
    @(negedge clk);
    check({serr_seen, act}, 2'b10);
    cam_u.frame(1'b0);
    bytes(8'h51, 4, 1'b0);
    get(w4(8'h51));
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_pack8;
    t_wide;
    t_overrun;
    t_syncerr;
    setup(WIDTH_8, 1'b0, 1'b0, 1'b0, 1'b1);
    cam_u.frame(1'b0);
    bytes(8'hA1, 4, 1'b1);
    get(w4(8'hA1));
    setup(WIDTH_12, 1'b1, 1'b1, 1'b1, 1'b1);
    bytes(8'hC1, 4, 1'b0);
    get(w4(8'hC1));
    results;
  end
  // Far beyond the roughly 30 us the scenarios need
  initial begin
    #2000000;
    errors++;
    results;
  end
endmodule
